// File: shared/hdlc_stat_pkg.sv
// constants and carrier types for the signaling status block
// assumes an apb master on pclk and a receive engine on the same clock
package hdlc_stat_pkg;

    // register byte addresses
    localparam logic [7:0] SIG_STATUS_OFS = 8'h64;
    localparam logic [7:0] RX_STATUS_OFS  = 8'h68;
    localparam logic [7:0] CTRL_OFS       = 8'h6C;
    localparam logic [7:0] CMD_OFS        = 8'h70;
    localparam logic [7:0] ADDR_MATCH_OFS = 8'h74;
    localparam logic [7:0] TX_DATA_OFS    = 8'h78;

    // signaling_channel_status bit positions
    localparam int SIS_TX_OVF  = 7;
    localparam int SIS_TX_WP   = 6;
    localparam int SIS_TX_REP  = 5;
    localparam int SIS_RX_IDLE = 3;
    localparam int SIS_CMD     = 2;
    localparam int SIS_FREEZE  = 1;

    // control and command fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RX_CHECK_ENABLE     = 3;
    localparam int CTRL_SS7      = 4;
    localparam int CMD_TX_RESET  = 0;
    localparam int CMD_TX_REPEAT = 1;
    localparam logic [4:0]  CTRL_RST       = 5'h00;
    localparam logic [31:0] ADDR_MATCH_RST = 32'h0000_0000;

    // mode codes, fixed addresses, result codes
    localparam logic [2:0] MODE_ADDR8  = 3'h2;
    localparam logic [2:0] MODE_ADDR16 = 3'h3;
    localparam logic [7:0] BCAST_A     = 8'hFE;
    localparam logic [7:0] BCAST_B     = 8'hFC;
    localparam logic [7:0] CR_MASK     = 8'hFD;
    localparam logic [1:0] HA_MATCH_B  = 2'h0;
    localparam logic [1:0] HA_BCAST    = 2'h1;
    localparam logic [1:0] SU_NONE     = 2'h0;
    localparam logic [1:0] SU_FISU     = 2'h1;
    localparam logic [1:0] SU_LSSU     = 2'h2;
    localparam logic [1:0] SU_MSU      = 2'h3;
    localparam logic [1:0] LEN_OK      = 2'h0;
    localparam logic [1:0] LEN_SHORT   = 2'h1;
    localparam logic [1:0] LEN_DROP    = 2'h2;

    // counts and times
    localparam int TX_HALF_BYTES  = 32;
    localparam int SS7_MAX_OCTETS = 272 + 7;
    localparam int IDLE_SLOTS     = 64;
    localparam int CLK_NS         = 4;
    localparam int CMD_BUSY_NS    = 1220;
    localparam int CMD_BUSY_CYC   = (CMD_BUSY_NS + CLK_NS - 1) / CLK_NS;

    // events from the receive bit engine
    typedef struct packed {
        logic       flag_seen;
        logic       slot;
        logic       byte_vld;
        logic [7:0] byte_val;
        logic       eof;
        logic       bits_ok;
        logic       crc_ok;
        logic       abort;
        logic       fifo_ovf;
    } rx_evt_t;

    // per-frame status byte, bit 7 first
    typedef struct packed {
        logic       valid_frame_flag;
        logic       rx_overflow_flag;
        logic       crc_ok;
        logic       rx_aborted_flag;
        logic [1:0] ha;
        logic       cr;
        logic       la;
    } rx_stat_t;

endpackage

// File: hw/hdlc_status_reporting.sv
// signaling channel status and per-frame receive status for hdlc channel 1
// assumes apb on pclk, receive engine and tx fifo mover on pclk too
`timescale 1ns/10ps
module hdlc_status_reporting
#(
    parameter int ADDR_W  = 8,
    parameter int TX_HALF = hdlc_stat_pkg::TX_HALF_BYTES,
    parameter int IDLE_N  = hdlc_stat_pkg::IDLE_SLOTS
)
(
    // clock, reset, enable
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  clk_en,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // receive engine and freeze state
    input  wire hdlc_stat_pkg::rx_evt_t rx_evt,
    input  wire logic                  signaling_freeze_state,
    // tx fifo mover and status
    input  wire logic                  tx_half_moved,
    output logic                       tx_fifo_write_permit,
    output logic                       tx_repeat,
    output logic                       tx_reset_pulse,
    // status byte into the rx fifo
    output logic                       stat_wr,
    output hdlc_stat_pkg::rx_stat_t    stat_byte
);
    import hdlc_stat_pkg::*;

    // the decoder reads paddr[7:0], so narrower buses cannot be served
    if (ADDR_W < 8 || TX_HALF < 1 || IDLE_N < 1)
    begin : g_param_chk
        $error("unsupported parameter values");
    end

    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b001,
        ST_FRAME = 3'b010,
        ST_DONE  = 3'b100
    } frame_st_t;

    localparam int TXC_W  = $clog2(TX_HALF + 1);
    localparam int IDLE_W = $clog2(IDLE_N + 1);
    localparam int BUSY_W = $clog2(CMD_BUSY_CYC + 1);

    frame_st_t        state_r;
    logic [TXC_W-1:0] tx_cnt_r;
    logic             tx_ovf_r;
    logic             tx_rep_r;
    logic [BUSY_W-1:0] busy_cnt_r;
    logic [IDLE_W-1:0] idle_cnt_r;
    logic             line_idle_r;
    logic [4:0]       ctrl_r;
    logic [31:0]      amatch_r;
    logic [11:0]      len_r;
    logic [7:0]       addr0_r;
    logic [7:0]       addr1_r;
    logic [7:0]       li_r;
    logic             rx_ovf_r;
    logic             rx_abt_r;
    rx_stat_t         stat_r;
    rx_stat_t         stat_nxt;
    logic [31:0]      rdata_nxt;
    logic [31:0]      prdata_r;

    logic [2:0] mode;
    logic       rx_check_enable;
    logic       ss7;
    logic       wr_acc;
    logic       setup;
    logic       cmd_wr;
    logic       data_wr;
    logic       busy;
    logic [1:0] len_cls;

    // true for any mapped register address
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        logic [7:0] b;
        b = a[7:0];
        addr_hit = (b == SIG_STATUS_OFS) || (b == RX_STATUS_OFS) ||
                   (b == CTRL_OFS) || (b == CMD_OFS) ||
                   (b == ADDR_MATCH_OFS) || (b == TX_DATA_OFS);
    endfunction

    // compare ignoring the c/r bit
    function automatic logic hi_eq(input logic [7:0] a, input logic [7:0] b);
        hi_eq = ((a ^ b) & CR_MASK) == 8'h00;
    endfunction

    // length class of a finished frame
    function automatic logic [1:0] len_class(input logic [2:0]  m,
                                             input logic        crc_on,
                                             input logic [11:0] n);
        logic [11:0] lim;
        len_class = LEN_OK;
        lim = 12'h000;
        if (m == MODE_ADDR16)
            lim = crc_on ? 12'h003 : 12'h004;
        else if (m == MODE_ADDR8)
            lim = crc_on ? 12'h002 : 12'h003;
        if (n == 12'h000)
            len_class = LEN_DROP;
        else if (lim != 12'h000 && n < lim)
            len_class = LEN_DROP;
        else if (lim != 12'h000 && n <= lim + 12'h001 && n >= lim)
            len_class = (m == MODE_ADDR16 && !crc_on) ||
                        (m == MODE_ADDR8 && !crc_on) ?
                        ((n == lim) ? LEN_SHORT : LEN_OK) : LEN_SHORT;
    endfunction

    assign mode    = ctrl_r[CTRL_MODE_LSB +: 3];
    assign rx_check_enable    = ctrl_r[CTRL_RX_CHECK_ENABLE];
    assign ss7     = ctrl_r[CTRL_SS7];
    assign setup   = psel && !penable && clk_en;
    assign wr_acc  = psel && penable && pwrite && clk_en;
    assign busy    = busy_cnt_r != '0;
    assign cmd_wr  = wr_acc && (paddr[7:0] == CMD_OFS) && !busy;
    assign data_wr = wr_acc && (paddr[7:0] == TX_DATA_OFS);
    assign len_cls = len_class(mode, rx_check_enable, len_r);

    assign pready  = clk_en;
    assign pslverr = psel && penable && !addr_hit(paddr);
    assign prdata  = prdata_r;

    // control and address compare registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r   <= CTRL_RST;
            amatch_r <= ADDR_MATCH_RST;
        end
        else if (wr_acc && paddr[7:0] == CTRL_OFS)
            ctrl_r <= pwdata[4:0];
        else if (wr_acc && paddr[7:0] == ADDR_MATCH_OFS)
            amatch_r <= pwdata;
    end

    // command register: repeat control and busy window
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_rep_r   <= 1'b0;
            busy_cnt_r <= '0;
        end
        else if (clk_en)
        begin
            if (cmd_wr)
            begin
                tx_rep_r   <= pwdata[CMD_TX_REPEAT];
                busy_cnt_r <= BUSY_W'(CMD_BUSY_CYC);
            end
            else if (busy)
                busy_cnt_r <= busy_cnt_r - 1'b1;
        end
    end

    // tx fifo fill count and overflow; a new byte wins over a clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_cnt_r <= '0;
            tx_ovf_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (data_wr && tx_cnt_r == TXC_W'(TX_HALF))
                tx_ovf_r <= 1'b1;
            else if (tx_half_moved || (cmd_wr && pwdata[CMD_TX_RESET]))
                tx_ovf_r <= 1'b0;
            if (tx_half_moved || (cmd_wr && pwdata[CMD_TX_RESET]))
                tx_cnt_r <= data_wr ? TXC_W'(1) : '0;
            else if (data_wr && tx_cnt_r != TXC_W'(TX_HALF))
                tx_cnt_r <= tx_cnt_r + 1'b1;
        end
    end

    assign tx_fifo_write_permit = tx_cnt_r < TXC_W'(TX_HALF);
    assign tx_repeat            = tx_rep_r;
    assign tx_reset_pulse       = cmd_wr && pwdata[CMD_TX_RESET];

    // line activity watch over signaling slots
    // count starts saturated so a slot after reset keeps the idle flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idle_cnt_r  <= IDLE_W'(IDLE_N);
            line_idle_r <= 1'b1;
        end
        else if (clk_en)
        begin
            if (rx_evt.flag_seen || rx_evt.byte_vld)
            begin
                idle_cnt_r  <= '0;
                line_idle_r <= 1'b0;
            end
            else if (rx_evt.slot && idle_cnt_r != IDLE_W'(IDLE_N))
            begin
                idle_cnt_r  <= idle_cnt_r + 1'b1;
                line_idle_r <= (idle_cnt_r + 1'b1) == IDLE_W'(IDLE_N);
            end
        end
    end

    // frame sequencing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_r <= ST_IDLE;
        else if (clk_en)
        begin
            case (state_r)
                ST_IDLE:
                    if (rx_evt.byte_vld)
                        state_r <= ST_FRAME;
                ST_FRAME:
                    if (rx_evt.eof)
                        state_r <= (len_cls == LEN_DROP) ? ST_IDLE
                                                         : ST_DONE;
                ST_DONE:
                    state_r <= rx_evt.byte_vld ? ST_FRAME : ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // byte count and address capture
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            len_r   <= 12'h000;
            addr0_r <= 8'h00;
            addr1_r <= 8'h00;
            li_r    <= 8'h00;
        end
        else if (clk_en && rx_evt.byte_vld)
        begin
            if (state_r != ST_FRAME)
            begin
                len_r   <= 12'h001;
                addr0_r <= rx_evt.byte_val;
            end
            else
            begin
                if (len_r != 12'hFFF)
                    len_r <= len_r + 12'h001;
                if (len_r == 12'h001)
                    addr1_r <= rx_evt.byte_val;
                if (len_r == 12'h002)
                    li_r <= rx_evt.byte_val;
            end
        end
    end

    // per-frame overflow and abort; an event wins over the frame-start clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_ovf_r <= 1'b0;
            rx_abt_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rx_evt.fifo_ovf)
                rx_ovf_r <= 1'b1;
            else if (state_r != ST_FRAME && rx_evt.byte_vld)
                rx_ovf_r <= 1'b0;
            if (rx_evt.abort)
                rx_abt_r <= 1'b1;
            else if (state_r != ST_FRAME && rx_evt.byte_vld)
                rx_abt_r <= 1'b0;
        end
    end

    // status byte built at end of frame
    always_comb
    begin
        logic [7:0] lo;
        logic [7:0] ral_a;
        logic [7:0] ral_b;
        logic [5:0] li;
        lo      = (mode == MODE_ADDR16) ? addr1_r : addr0_r;
        ral_a   = amatch_r[23:16];
        ral_b   = amatch_r[31:24];
        li      = li_r[5:0];
        stat_nxt = '0;
        stat_nxt.valid_frame_flag    = rx_evt.bits_ok && (len_cls == LEN_OK);
        stat_nxt.rx_overflow_flag    = rx_ovf_r || rx_evt.fifo_ovf;
        stat_nxt.crc_ok = rx_evt.crc_ok;
        stat_nxt.rx_aborted_flag    = rx_abt_r || rx_evt.abort ||
                          (ss7 && len_r > 12'(SS7_MAX_OCTETS));
        if (ss7)
        begin
            if (len_r < 12'h003)
                stat_nxt.ha = SU_NONE;
            else if (li == 6'h00)
                stat_nxt.ha = SU_FISU;
            else if (li <= 6'h02)
                stat_nxt.ha = SU_LSSU;
            else
                stat_nxt.ha = SU_MSU;
        end
        else if (mode == MODE_ADDR16)
        begin
            stat_nxt.cr = addr0_r[1];
            if (hi_eq(addr0_r, amatch_r[7:0]))
                stat_nxt.ha = {1'b1, addr0_r[1]};
            else if (hi_eq(addr0_r, BCAST_A) || hi_eq(addr0_r, BCAST_B))
                stat_nxt.ha = HA_BCAST;
            else
                stat_nxt.ha = HA_MATCH_B;
        end
        if (!ss7 && (mode == MODE_ADDR16 || mode == MODE_ADDR8))
            stat_nxt.la = (lo == ral_a) ? 1'b1 :
                          ((lo == ral_b) ? 1'b0 : 1'b0);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stat_r <= '0;
        else if (clk_en && state_r == ST_FRAME && rx_evt.eof)
            stat_r <= stat_nxt;
    end

    assign stat_wr   = clk_en && (state_r == ST_DONE);
    assign stat_byte = stat_r;

    // read data captured in the setup cycle
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        case (paddr[7:0])
            SIG_STATUS_OFS:
            begin
                rdata_nxt[SIS_TX_OVF]  = tx_ovf_r;
                rdata_nxt[SIS_TX_WP]   = tx_fifo_write_permit;
                rdata_nxt[SIS_TX_REP]  = tx_rep_r;
                rdata_nxt[SIS_RX_IDLE] = line_idle_r;
                rdata_nxt[SIS_CMD]     = busy;
                rdata_nxt[SIS_FREEZE]  = signaling_freeze_state;
            end
            RX_STATUS_OFS:  rdata_nxt[7:0] = stat_r;
            CTRL_OFS:       rdata_nxt[4:0] = ctrl_r;
            CMD_OFS:        rdata_nxt[CMD_TX_REPEAT] = tx_rep_r;
            ADDR_MATCH_OFS: rdata_nxt = amatch_r;
            TX_DATA_OFS:    rdata_nxt[TXC_W-1:0] = tx_cnt_r;
            default:        rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h0000_0000;
        else if (setup)
            prdata_r <= rdata_nxt;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !clk_en);

    a_tx_ovf_set: assert property (
        data_wr && tx_cnt_r == TXC_W'(TX_HALF) |=> tx_ovf_r)
        else $error("tx overflow not set after extra byte");
    a_tx_ovf_clr: assert property (
        tx_half_moved && !data_wr |=> !tx_ovf_r && tx_cnt_r == '0)
        else $error("tx overflow not cleared by takeover");
    a_tx_permit: assert property (
        data_wr && tx_cnt_r == TXC_W'(TX_HALF - 1) && !tx_half_moved
        && !tx_reset_pulse |=> !tx_fifo_write_permit)
        else $error("write permit with full fifo");
    a_cmd_busy: assert property (
        cmd_wr |=> busy [*8])
        else $error("command flag dropped too early");
    a_cmd_end: assert property (
        cmd_wr |-> ##[300:306] !busy)
        else $error("command flag did not end in time");
    a_short_drop: assert property (
        state_r == ST_FRAME && rx_evt.eof && len_cls == LEN_DROP
        |=> !stat_wr)
        else $error("status written for dropped frame");
    a_stat_after_eof: assert property (
        stat_wr |-> $past(rx_evt.eof) && $past(state_r) == ST_FRAME)
        else $error("status byte without end of frame");
    a_vfr_bits: assert property (
        state_r == ST_FRAME && rx_evt.eof && !rx_evt.bits_ok
        && len_cls != LEN_DROP |=> stat_wr && !stat_byte.valid_frame_flag)
        else $error("non-octet frame reported valid");
    a_ha_silent: assert property (
        stat_wr && !ss7 && mode != MODE_ADDR16 |-> stat_byte.ha == 2'h0)
        else $error("high result set outside 2-byte modes");
    a_ss7_long: assert property (
        state_r == ST_FRAME && rx_evt.eof && ss7
        && len_r > 12'(SS7_MAX_OCTETS) |=> stat_byte.rx_aborted_flag)
        else $error("long ss7 frame not aborted");
    a_crc_copy: assert property (
        state_r == ST_FRAME && rx_evt.eof
        |=> stat_byte.crc_ok == $past(rx_evt.crc_ok))
        else $error("crc result not carried");

endmodule

// File: test/far_station.sv
// remote hdlc station model driving the receive engine events
// assumes the bench calls send and slots right after a rising pclk
`timescale 1ns/10ps
module far_station
(
    input  wire logic              pclk,
    output hdlc_stat_pkg::rx_evt_t rx_evt
);
    import hdlc_stat_pkg::*;

    initial rx_evt = '0;

    // f holds bits_ok, crc_ok, abort, fifo_ovf; gap slows the bytes
    task automatic send(input logic [7:0] b[$], input logic [3:0] f,
                        input int gap);
        foreach (b[i])
        begin
            @(posedge pclk);
            rx_evt.byte_vld <= 1'b1;
            rx_evt.byte_val <= b[i];
            rx_evt.fifo_ovf <= f[0] && i == 0;
            repeat (gap)
            begin
                @(posedge pclk);
                rx_evt.byte_vld <= 1'b0;
                rx_evt.fifo_ovf <= 1'b0;
                rx_evt.byte_val <= ~b[i];
            end
        end
        @(posedge pclk);
        rx_evt.byte_vld <= 1'b0;
        rx_evt.fifo_ovf <= 1'b0;
        rx_evt.byte_val <= ~b[b.size() - 1];
        // far-end abort comes with the closing event
        {rx_evt.eof, rx_evt.bits_ok, rx_evt.crc_ok, rx_evt.abort}
            <= {1'b1, f[3:1]};
        @(posedge pclk);
        {rx_evt.eof, rx_evt.bits_ok, rx_evt.crc_ok, rx_evt.abort} <= 4'h0;
        rx_evt.byte_val <= b[b.size() - 1];
    endtask

    task automatic slots(input int n, input logic fl);
        repeat (n)
        begin
            @(posedge pclk);
            rx_evt.slot      <= 1'b1;
            rx_evt.flag_seen <= fl;
        end
        @(posedge pclk);
        rx_evt.slot      <= 1'b0;
        rx_evt.flag_seen <= 1'b0;
    endtask
endmodule

// File: test/hdlc_status_reporting_bench.sv
// bench: apb master, far station and a frame status reference model
// assumes the package and far_station compile first
`timescale 1ns/10ps
module hdlc_status_reporting_bench;
    import hdlc_stat_pkg::*;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, pready;
    logic        pslverr, signaling_freeze_state, tx_half_moved, err;
    logic        tx_fifo_write_permit, tx_repeat, tx_reset_pulse, rp;
    logic        stat_wr, rc, ss7;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, am;
    logic [2:0]  md;
    logic [3:0]  f;
    logic [15:0] ev;
    logic [7:0]  q[$];
    logic [15:0] exp_q[$];
    rx_evt_t     rx_evt;
    rx_stat_t    stat_byte;
    int          mismatches, n_checks, seed, n, e;

    hdlc_status_reporting #(.IDLE_N(2)) dut (.pclk, .presetn, .clk_en,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .rx_evt, .signaling_freeze_state, .tx_half_moved,
        .tx_fifo_write_permit, .tx_repeat, .tx_reset_pulse, .stat_wr,
        .stat_byte);
    far_station far (.pclk, .rx_evt);

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask

    task automatic final_report;
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (int k = 0; pready !== 1'b1; k++)
        begin
            if (k == 20)
            begin
                mismatches++;
                final_report;
            end
            @(posedge pclk);
        end
        {rd, err, rp} = {prdata, pslverr, tx_reset_pulse};
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_idle;
        for (int k = 0; rd[SIS_CMD] !== 1'b0; k++)
        begin
            if (k == 200)
            begin
                mismatches++;
                final_report;
            end
            apb(0, SIG_STATUS_OFS, 0);
        end
    endtask

    function automatic int model(input int n, input logic [3:0] f);
        int         lo;
        logic [7:0] v;
        logic [7:0] m;
        lo = (md == MODE_ADDR16) ? 4 : 3;
        if (n < lo - rc)
            return -1;
        v = {f[3] && n != lo && !(rc && n == lo - 1), f[0], f[2],
             f[1] || (ss7 && n > SS7_MAX_OCTETS), 4'h0};
        m = 8'hFF;
        if (ss7)
        begin
            v[3:2] = q[2][5:0] == 0 ? SU_FISU :
                     q[2][5:0] < 3 ? SU_LSSU : SU_MSU;
        end
        else if (md == MODE_ADDR16)
        begin
            v[1] = q[0][1];
            v[3:2] = ((q[0] ^ am[7:0]) & CR_MASK) == 0 ? {1'b1, q[0][1]} :
                     (q[0] == BCAST_A || q[0] == BCAST_B) ? HA_BCAST :
                     HA_MATCH_B;
        end
        if (!ss7)
            v[0] = q[lo - 3] == am[23:16];
        return {16'h0, m, v & m};
    endfunction

    always @(posedge pclk)
        if (stat_wr === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(1, 0);
            else
            begin
                ev = exp_q.pop_front();
                chk(stat_byte & ev[15:8], ev[7:0]);
            end
        end

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {signaling_freeze_state, tx_half_moved} = 2'b00;
        {clk_en, mismatches, n_checks, seed} = {1'b1, 32'd0, 32'd0, 32'd15};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, SIG_STATUS_OFS, 0);
        chk(rd & 32'hEE, 32'h48);
        apb(0, 8'h40, 0);
        chk({err, rd}, {1'b1, 32'h0});
        for (int v = 1; v >= 0; v--)
        begin
            signaling_freeze_state <= v[0];
            apb(0, SIG_STATUS_OFS, 0);
            chk(rd[SIS_FREEZE], v[0]);
        end
        repeat (32) apb(1, TX_DATA_OFS, 0);
        apb(0, SIG_STATUS_OFS, 0);
        chk({rd[7:6], tx_fifo_write_permit}, 3'b000);
        apb(1, TX_DATA_OFS, 0);
        apb(0, SIG_STATUS_OFS, 0);
        chk(rd[7:6], 2'b10);
        tx_half_moved <= 1'b1;
        @(posedge pclk);
        tx_half_moved <= 1'b0;
        apb(0, SIG_STATUS_OFS, 0);
        chk(rd[7:6], 2'b01);
        repeat (33) apb(1, TX_DATA_OFS, 0);
        apb(1, CMD_OFS, 32'h1);
        chk(rp, 1'b1);
        apb(0, SIG_STATUS_OFS, 0);
        chk({rd[7], rd[SIS_CMD]}, 2'b01);
        wait_idle;
        apb(1, CMD_OFS, 32'h2);
        apb(1, CMD_OFS, 32'h0);
        apb(0, SIG_STATUS_OFS, 0);
        chk({tx_repeat, rd[SIS_TX_REP], rd[SIS_CMD]}, 3'b111);
        wait_idle;
        apb(1, CMD_OFS, 32'h0);
        apb(0, SIG_STATUS_OFS, 0);
        chk({tx_repeat, rd[SIS_TX_REP]}, 2'b00);
        wait_idle;
        for (int i = 0; i < 40; i++)
        begin
            md = i[0] ? MODE_ADDR16 : MODE_ADDR8;
            {rc, ss7} = {i[1], i % 8 == 7};
            am = $random(seed);
            if (i[2])
                am[15:8] = am[7:0];
            apb(1, CTRL_OFS, {27'h0, ss7, rc, md});
            apb(1, ADDR_MATCH_OFS, am);
            n = 1 + $unsigned($random(seed)) % 7;
            n = i == 23 ? 280 : i == 15 ? 279 : ss7 && n < 3 ? 3 : n;
            q = {};
            repeat (n) q.push_back($random(seed));
            case (i % 5)
                0: q[0] = am[7:0] ^ 8'h02;
                1: q[0] = am[15:8];
                2: q[0] = BCAST_A;
                3: q[0] = BCAST_B;
                default: ;
            endcase
            if (i % 3 == 0 && n > md[0])
                q[md[0]] = am[23:16];
            if (ss7)
                q[2] = {2'b00, 6'(i / 8)};
            f = $random(seed);
            e = model(n, f);
            if (e >= 0)
                exp_q.push_back(e[15:0]);
            far.send(q, f, i % 3);
            repeat (3) @(posedge pclk);
            chk(exp_q.size(), 0);
            apb(0, RX_STATUS_OFS, 0);
            if (e >= 0)
                chk(rd[7:0], e[7:0]);
        end
        clk_en <= 1'b0;
        far.slots(3, 1'b0);
        clk_en <= 1'b1;
        apb(0, SIG_STATUS_OFS, 0);
        chk(rd[SIS_RX_IDLE], 1'b0);
        far.slots(3, 1'b0);
        apb(0, SIG_STATUS_OFS, 0);
        chk(rd[SIS_RX_IDLE], 1'b1);
        far.slots(2, 1'b1);
        apb(0, SIG_STATUS_OFS, 0);
        chk(rd[SIS_RX_IDLE], 1'b0);
        final_report;
    end
endmodule
